//--- inc/ipo_pkg.sv
// Package of constants and types for the interrupt pin output control block.
package ipo_pkg;
    localparam logic [7:0] IPO_ADDR_CFG4 = 8'h18;
    localparam logic [7:0] IPO_ADDR_CTRL = 8'h20;
    localparam logic [7:0] IPO_ADDR_STAT = 8'h21;
    localparam int IPO_BIT_POL = 0;
    localparam int IPO_BIT_DRV = 1;
    localparam int IPO_BIT_PULSE = 3;
    localparam logic [7:0] IPO_CFG4_RST = 8'h01;
    localparam logic [7:0] IPO_CFG4_MASK = 8'h0b;
    localparam int IPO_CTRL_SOFT = 0;
    localparam int IPO_CTRL_HIB = 1;
    localparam int IPO_CLK_MHZ = 100;
    localparam int IPO_PULSE_NS = 32000;
    localparam int IPO_PULSE_CYC = IPO_PULSE_NS * IPO_CLK_MHZ / 1000;
    localparam logic [11:0] IPO_PULSE_CNT = 12'(IPO_PULSE_CYC);
    localparam logic [3:0] IPO_DECIM_DEF = 4'h1;
    localparam logic [3:0] IPO_DECIM_RST = 4'h0;
    typedef struct packed {
        logic dat;
        logic oe;
    } ipo_pin_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ipo_bus_t;
endpackage

//--- rtl/ipo_pin_drv.sv
// One interrupt pin driver: level and enable from event, polarity, driver type and strap.
`timescale 1ns/1ns
`default_nettype none
module ipo_pin_drv
    import ipo_pkg::*;
(
    input wire logic mclk_in, // Clock.
    input wire logic rst_n_in, // Asynchronous reset, active low.
    input wire logic event_in, // Asserted event, active high.
    input wire logic pol_in, // Polarity select, 1 is active high.
    input wire logic od_in, // Driver type select, 1 is open-drain or open-source.
    input wire logic strap_in, // Boot-mode strap.
    output var ipo_pkg::ipo_pin_t pin_out // Pin data and output enable.
);
    import ipo_pkg::*;
    ipo_pin_t pin_r;
    ipo_pin_t pin_nxt;
    logic act;
    always_comb
    begin
        // The level is worked out on every path so that no latch is inferred.
        act = pol_in ? event_in : ~event_in;
        pin_nxt = '{dat: 1'b0, oe: 1'b1};
        if (strap_in)
        begin
            pin_nxt.dat = 1'b0;
            pin_nxt.oe = event_in;
        end
        else
        begin
            pin_nxt.dat = act;
            pin_nxt.oe = od_in ? event_in : 1'b1;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pin_r <= '{dat: 1'b0, oe: 1'b0};
        else
            pin_r <= pin_nxt;
    end
    assign pin_out = pin_r;
    a_strap_od: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        strap_in |=> (pin_r.dat == 1'b0)) else $error("strap mode drove high");
    a_od_release: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!strap_in && od_in && !event_in) |=> !pin_r.oe) else $error("open drain not released");
    a_pp_drive: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!strap_in && !od_in) |=> pin_r.oe) else $error("push pull not driving");
    a_pol_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!strap_in && event_in) |=> (pin_r.dat == $past(pol_in))) else $error("polarity wrong");
    a_idle_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!strap_in && !od_in && !event_in) |=> (pin_r.dat != $past(pol_in))) else $error("idle wrong");
    a_strap_release: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (strap_in && !event_in) |=> !pin_r.oe) else $error("strap idle driven");
    a_os_drive: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (!strap_in && od_in && pol_in && event_in) |=> (pin_r.oe && pin_r.dat)) else $error("source bad");
    a_oe_event: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (od_in || strap_in) |=> (pin_r.oe == $past(event_in))) else $error("enable wrong");
    c_strap: cover property (@(posedge mclk_in) strap_in && event_in);
    c_od: cover property (@(posedge mclk_in) !strap_in && od_in && event_in);
    c_pp_low: cover property (@(posedge mclk_in) !strap_in && !od_in && !pol_in && event_in);
endmodule
`default_nettype wire

//--- rtl/ipo_ctrl.sv
// Interrupt pin output control: configuration register, ready pulse, trigger sequencing.
`timescale 1ns/1ns
`default_nettype none
module ipo_ctrl
    import ipo_pkg::*;
(
    input wire logic mclk_in, // Clock, 100 MHz.
    input wire logic rst_n_in, // Power-on reset, asynchronous, active low.
    input wire logic boot_mode_strap_in, // Boot-mode strap level.
    input wire logic [7:0] addr_in, // Register address.
    input wire logic [7:0] wdata_in, // Write data.
    input wire logic wr_in, // Write strobe.
    input wire logic rd_in, // Read strobe.
    input wire logic [1:0] event_in, // Routed interrupt events for pins a and b.
    input wire logic ready_event_in, // One-cycle data-ready event.
    input wire logic ext_trigger_in, // External trigger level.
    input wire logic [3:0] decim_in, // Measurements per trigger from decimation.
    output logic [7:0] rdata_out, // Read data, cycle after read strobe.
    output ipo_pkg::ipo_pin_t irq_pin_a_out, // Pin a data and enable.
    output ipo_pkg::ipo_pin_t irq_pin_b_out, // Pin b data and enable.
    output logic meas_req_out, // One-cycle measurement request.
    output logic motion_out // Motion-detection mode active.
);
    import ipo_pkg::*;
    typedef enum logic [1:0] {IPO_IDLE = 2'b01, IPO_ACQ = 2'b10} ipo_state_t;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic strap_r, strap_nxt, strap_ok_r;
    logic [11:0] pcnt_r, pcnt_nxt;
    logic [3:0] left_r, left_nxt;
    logic trig_d_r, req_r, req_nxt;
    ipo_state_t st_r, st_nxt;
    logic [1:0] ev;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction
    // Strap is caught once after reset release rather than inside the reset branch.
    always_comb
    begin
        strap_nxt = strap_ok_r ? strap_r : boot_mode_strap_in;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            strap_r <= 1'b0;
            strap_ok_r <= 1'b0;
        end
        else
        begin
            strap_r <= strap_nxt;
            strap_ok_r <= 1'b1;
        end
    end
    // Soft reset clears the other fields but keeps polarity and driver type; hibernation reloads the reset value IPO_CFG4_RST.
    always_comb
    begin
        cfg_nxt = cfg_r;
        rdata_nxt = 8'h00;
        if (wr_in && hit(addr_in, IPO_ADDR_CFG4))
            cfg_nxt = wdata_in & IPO_CFG4_MASK;
        if (wr_in && hit(addr_in, IPO_ADDR_CTRL))
        begin
            if (wdata_in[IPO_CTRL_HIB])
                cfg_nxt = IPO_CFG4_RST;
            else if (wdata_in[IPO_CTRL_SOFT])
                cfg_nxt = cfg_r & ((8'h01 << IPO_BIT_POL) | (8'h01 << IPO_BIT_DRV));
        end
        if (rd_in && hit(addr_in, IPO_ADDR_CFG4))
            rdata_nxt = cfg_r;
        else if (rd_in && hit(addr_in, IPO_ADDR_STAT))
            rdata_nxt = {4'h0, left_r[0], st_r == IPO_ACQ, req_r, strap_r};
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_r <= IPO_CFG4_RST;
            rdata_r <= 8'h00;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    // Ready pulse stretched to its nominal width and OR'd into both pins.
    always_comb
    begin
        pcnt_nxt = pcnt_r;
        if (ready_event_in && cfg_r[IPO_BIT_PULSE] && !strap_r)
            pcnt_nxt = IPO_PULSE_CNT;
        else if (pcnt_r != 12'h000)
            pcnt_nxt = pcnt_r - 12'h001;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pcnt_r <= 12'h000;
        else
            pcnt_r <= pcnt_nxt;
    end
    // One rising trigger edge runs the whole decimation burst; further edges are ignored until done.
    always_comb
    begin
        st_nxt = st_r;
        left_nxt = left_r;
        req_nxt = 1'b0;
        unique case (st_r)
            IPO_IDLE:
            begin
                if (ext_trigger_in && !trig_d_r && !strap_r)
                begin
                    st_nxt = IPO_ACQ;
                    left_nxt = (decim_in == IPO_DECIM_RST) ? IPO_DECIM_DEF : decim_in;
                end
            end
            IPO_ACQ:
            begin
                req_nxt = 1'b1;
                left_nxt = left_r - 4'h1;
                if (left_r == IPO_DECIM_DEF)
                    st_nxt = IPO_IDLE;
            end
            default:
            begin
                st_nxt = IPO_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_r <= IPO_IDLE;
            left_r <= IPO_DECIM_RST;
            trig_d_r <= 1'b0;
            req_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            left_r <= left_nxt;
            trig_d_r <= ext_trigger_in;
            req_r <= req_nxt;
        end
    end
    assign ev = event_in | {2{pcnt_r != 12'h000}};
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_pin
            ipo_pin_t p;
            ipo_pin_drv u_drv (
                .mclk_in(mclk_in),
                .rst_n_in(rst_n_in),
                .event_in(ev[g]),
                .pol_in(cfg_r[IPO_BIT_POL]),
                .od_in(cfg_r[IPO_BIT_DRV]),
                .strap_in(strap_r),
                .pin_out(p)
            );
        end
    endgenerate
    assign irq_pin_a_out = g_pin[0].p;
    assign irq_pin_b_out = g_pin[1].p;
    assign rdata_out = rdata_r;
    assign meas_req_out = req_r;
    assign motion_out = strap_r;
    a_soft_keep: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == IPO_ADDR_CTRL && wdata_in == 8'h01) |=> $stable(cfg_r[1:0]))
        else $error("soft reset lost pin settings");
    a_burst_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (st_r == IPO_IDLE && st_nxt == IPO_ACQ && decim_in == 4'h2) |=> ##1 req_r ##1 req_r ##1 !req_r)
        else $error("burst length wrong");
    c_burst: cover property (@(posedge mclk_in) st_r == IPO_ACQ);
    c_pulse: cover property (@(posedge mclk_in) pcnt_r == IPO_PULSE_CNT);
endmodule
`default_nettype wire

//--- dv/ipo_host_model.sv
// Host interrupt inputs with a board pull resistor on each pin.
`timescale 1ns/1ns
`default_nettype none
module ipo_host_model
    import ipo_pkg::*;
(
    input wire ipo_pkg::ipo_pin_t pin_a_in, // Pin a from the device.
    input wire ipo_pkg::ipo_pin_t pin_b_in, // Pin b from the device.
    input wire logic pull_up_in, // 1 fits pull-ups, 0 pull-downs.
    output logic level_a_out, // Level seen on pin a.
    output logic level_b_out // Level seen on pin b.
);
    // A released pin takes the resistor level; without one it would float.
    assign level_a_out = pin_a_in.oe ? pin_a_in.dat : pull_up_in;
    assign level_b_out = pin_b_in.oe ? pin_b_in.dat : pull_up_in;
endmodule
`default_nettype wire

//--- dv/ipo_ctrl_tb.sv
// Self-checking testbench for the interrupt pin output control block.
`timescale 1ns/1ns
`default_nettype none
`define IPO_CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin $display("MISMATCH %s expected %h seen %h", nm, exp, got); error_cnt++; end end
module ipo_ctrl_tb;
    import ipo_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic strap = 1'b0;
    ipo_bus_t bus = '0;
    logic [1:0] ev = 2'h0;
    logic rdy = 1'b0;
    logic trig = 1'b0;
    logic [3:0] decim = 4'h1;
    logic [7:0] rdata;
    ipo_pin_t pin_a;
    ipo_pin_t pin_b;
    logic meas_req;
    logic motion;
    logic lvl_a;
    logic lvl_b;
    logic pull_up = 1'b0;
    logic [1:0] look = 2'h0;
    logic rd_seen = 1'b0;
    logic [7:0] req_cnt = 8'h00;
    logic [15:0] notes[$];
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 56204;

    ipo_ctrl i_ipo_ctrl (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .boot_mode_strap_in(strap),
        .addr_in(bus.addr), .wdata_in(bus.wdata), .wr_in(bus.wr), .rd_in(bus.rd), .event_in(ev),
        .ready_event_in(rdy), .ext_trigger_in(trig), .decim_in(decim), .rdata_out(rdata),
        .irq_pin_a_out(pin_a), .irq_pin_b_out(pin_b), .meas_req_out(meas_req), .motion_out(motion));
    ipo_host_model i_ipo_host_model (.pin_a_in(pin_a), .pin_b_in(pin_b), .pull_up_in(pull_up),
        .level_a_out(lvl_a), .level_b_out(lvl_b));

    initial
    begin
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        notes.push_back({8'h00, exp});
        @(posedge mclk_in);
        bus.rd <= 1'b0;
    endtask

    // Kind 1 compares pins and motion, kind 2 the count of measurement requests.
    task automatic note(input logic [1:0] kind, input logic [15:0] exp);
        cyc(2);
        notes.push_back(exp);
        look <= kind;
        @(posedge mclk_in);
        look <= 2'h0;
    endtask

    // Returns the pin level seen by the host and the output enable.
    function automatic logic [1:0] pin_exp(input logic e, input logic p, input logic o, input logic s);
        if (s)
            return {~e, e};
        return {p ? e : ~e, o ? e : 1'b1};
    endfunction

    task automatic chk(input string nm, input logic [15:0] got);
        logic [15:0] exp;
        exp = (notes.size() == 0) ? 16'hxxxx : notes.pop_front();
        `IPO_CHK(nm, exp, got)
    endtask

    always @(posedge mclk_in)
    begin
        rd_seen <= bus.rd;
        if (meas_req === 1'b1)
            req_cnt <= req_cnt + 8'h01;
        if (rd_seen)
            chk("rdata", {8'h00, rdata});
        if (look == 2'h1)
            chk("pins", {11'h000, motion, lvl_b, pin_b.oe, lvl_a, pin_a.oe});
        if (look == 2'h2)
        begin
            chk("meas_count", {8'h00, req_cnt});
            req_cnt <= 8'h00;
        end
    end

    initial
    begin
        cyc(100000);
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        logic [1:0] e;
        logic [3:0] d;
        cyc(16);
        rst_n_in <= 1'b1;
        reg_rd(IPO_ADDR_CFG4, IPO_CFG4_RST);
        reg_rd(8'h33, 8'h00);
        for (int k = 0; k < 16; k++)
        begin
            reg_wr(IPO_ADDR_CFG4, {6'h00, k[1], k[0]});
            pull_up <= ~k[0];
            e = 2'($random(seed));
            @(posedge mclk_in);
            ev <= e;
            note(2'h1, {11'h000, 1'b0, pin_exp(e[1], k[0], k[1], 1'b0), pin_exp(e[0], k[0], k[1], 1'b0)});
        end
        ev <= 2'h0;
        for (int p = 0; p < 2; p++)
        begin
            reg_wr(IPO_ADDR_CFG4, {4'h0, 1'b1, 2'b00, p[0]});
            pull_up <= ~p[0];
            rdy <= 1'b1;
            @(posedge mclk_in);
            rdy <= 1'b0;
            note(2'h1, {11'h000, 1'b0, p[0], 1'b1, p[0], 1'b1});
            cyc(3140);
            note(2'h1, {11'h000, 1'b0, p[0], 1'b1, p[0], 1'b1});
            cyc(100);
            note(2'h1, {11'h000, 1'b0, ~p[0], 1'b1, ~p[0], 1'b1});
        end
        reg_wr(IPO_ADDR_CFG4, 8'h0a);
        reg_wr(IPO_ADDR_CTRL, 8'h01);
        cyc(4);
        reg_rd(IPO_ADDR_CFG4, 8'h02);
        reg_wr(IPO_ADDR_CTRL, 8'h02);
        cyc(4);
        reg_rd(IPO_ADDR_CFG4, IPO_CFG4_RST);
        for (int k = 0; k < 5; k++)
        begin
            d = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : (k == 2) ? 4'h2 : 4'($random(seed));
            @(posedge mclk_in);
            decim <= d;
            trig <= 1'b1;
            cyc(3);
            trig <= 1'b0;
            cyc(22);
            note(2'h2, {12'h000, (d == 4'h0) ? 4'h1 : d});
        end
        // A second power reset with the strap high checks the forced pin mode.
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        strap <= 1'b1;
        cyc(4);
        rst_n_in <= 1'b1;
        reg_wr(IPO_ADDR_CFG4, 8'h03);
        pull_up <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            e = 2'($random(seed));
            @(posedge mclk_in);
            ev <= e;
            note(2'h1, {11'h000, 1'b1, pin_exp(e[1], 1'b1, 1'b1, 1'b1), pin_exp(e[0], 1'b1, 1'b1, 1'b1)});
        end
        reg_rd(IPO_ADDR_STAT, 8'h01);
        cyc(4);
        if (notes.size() != 0)
            error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
